/* hw/slcd_pkg.sv */
// Package with register map, field layout and timing constants of the LCD control
package slcd_pkg;
    // ==================================================================
    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_CTRL_A = 10'h0e4;
    localparam logic [9:0] IDX_CTRL_B = 10'h0e5;
    localparam logic [9:0] IDX_FRAME = 10'h0e6;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL_A = {IDX_CTRL_A, 2'b00};
    localparam logic [11:0] ADDR_CTRL_B = {IDX_CTRL_B, 2'b00};
    localparam logic [11:0] ADDR_FRAME = {IDX_FRAME, 2'b00};

    // ==================================================================
    // Control register A fields
    localparam int A_EN = 7;
    localparam int A_WAVE = 6;
    localparam int A_FLAG = 4;
    localparam int A_IE = 3;
    localparam int A_BLANK = 0;
    // Control register B fields
    localparam int B_CS = 7;
    localparam int B_HALF = 6;
    localparam int B_DUTY_LO = 4;
    localparam int B_PM_LO = 0;
    localparam int B_PM_TOP = 3;
    // Frame rate register fields
    localparam int F_PS_LO = 4;
    localparam int F_CD_LO = 0;
    // Reset value of every register
    localparam logic [7:0] REG_RESET = 8'h00;

    // ==================================================================
    // Duty codes and last frame phases (frame length minus one) in prescaled clock ticks
    localparam logic [1:0] DUTY_STATIC = 2'h0;
    localparam logic [1:0] DUTY_THIRD = 2'h2;
    localparam logic [2:0] FRAME_K_STD = 3'h7;
    localparam logic [2:0] FRAME_K_THIRD = 3'h5;
    // Prescaler width and segment pin count
    localparam int PRE_W = 12;
    localparam int SEG_N = 40;
    localparam int COM_N = 4;
    // Segment counts per port mask code
    localparam logic [5:0] SEG_BASE = 6'h0d;
    localparam logic [5:0] SEG_BASE_HI = 6'h1b;
    localparam logic [5:0] SEG_C6 = 6'h18;
    localparam logic [5:0] SEG_C7 = 6'h19;
    localparam logic [5:0] SEG_C15 = 6'h28;

    // Controller run states: idle and running
    typedef enum logic [1:0] {SLCD_IDLE, SLCD_RUN} slcd_state_t;
endpackage

/* hw/slcd_edge_sync.sv */
// Two-flop synchroniser and rising-edge detector for the slow LCD clock
`timescale 1ns/1ps
module slcd_edge_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic async_in,
    output logic rise
);
    // ==================================================================
    // Synchroniser stages and edge history
    logic meta; // First stage, read only by the second stage
    logic stab; // Second stage
    logic hist; // Previous stable level

    // Resample the foreign clock and catch its rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            stab <= 1'b0;
            hist <= 1'b0;
            rise <= 1'b0;
        end else if (ce) begin
            meta <= async_in;
            stab <= meta;
            hist <= stab;
            rise <= stab & ~hist;
        end
    end
endmodule

/* hw/slcd_clk_gen.sv */
// Prescaler and clock divider producing the prescaled display clock tick
`timescale 1ns/1ps
module slcd_clk_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic run,
    input wire logic lcd_tick,
    input wire logic [2:0] prescaler_tap,
    input wire logic [2:0] clock_divider_sel,
    output logic prescaled_display_clock
);
    // ==================================================================
    // Counters
    logic [slcd_pkg::PRE_W-1:0] pre_cnt; // Free prescaler
    logic [2:0] div_cnt; // Divider count
    logic [slcd_pkg::PRE_W-1:0] tap_mask; // Low bits that must be all ones
    logic tap_hit; // Prescaler tap fires

    // Tap code to mask: 16, 64, 128 .. 4096
    function automatic logic [slcd_pkg::PRE_W-1:0] tap_fn(input logic [2:0] c);
        logic [slcd_pkg::PRE_W-1:0] m;
        m = {slcd_pkg::PRE_W{1'b1}};
        if (c == 3'h0)
            tap_fn = m >> (slcd_pkg::PRE_W - 4);
        else
            tap_fn = m >> (slcd_pkg::PRE_W - 5 - int'(c));
    endfunction

    assign tap_mask = tap_fn(prescaler_tap);
    assign tap_hit = lcd_tick && ((pre_cnt & tap_mask) == tap_mask);

    // Prescaler, then divide by field plus one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= '0;
            div_cnt <= 3'h0;
            prescaled_display_clock <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                pre_cnt <= '0;
                div_cnt <= 3'h0;
                prescaled_display_clock <= 1'b0;
            end else begin
                if (lcd_tick)
                    pre_cnt <= pre_cnt + 1'b1;
                prescaled_display_clock <= 1'b0;
                if (tap_hit) begin
                    if (div_cnt >= clock_divider_sel) begin
                        div_cnt <= 3'h0;
                        prescaled_display_clock <= 1'b1;
                    end else begin
                        div_cnt <= div_cnt + 3'h1;
                    end
                end
            end
        end
    end
endmodule

/* hw/slcd_ctrl.sv */
// Segment LCD controller: APB registers, frame timing and pin control
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
// Contract
// - Enable bit starts drive, clearing stops at once
// - Disabled: pins return to port function
// - Waveform select takes effect at next frame
// - Frame flag set when display data latched
// - Interrupt when flag, enable and global enable
// - Flag cleared by vector or writing one
// - Low-power waveform sets flag every second frame
// - Reserved bits always read zero
// - Blanking grounds all pins after current frame
// - Clock select: system or asynchronous clock
// - Async source: oscillator or external input
// - Bias select: one third or half
// - Duty field picks number of commons
// - Unused commons stay port pins
// - Static duty always uses static bias
// - Port mask sets driven segment count
// - Segments above mask stay port pins
// - Narrow variant: mask top bit reads zero
// - Prescaler tap divides by 16 to 4096
// - Tap feeds divider, giving prescaled clock
// - Divider factor is field plus one
// - Frame is K prescaled ticks, K 8 or 6
// - Blank and waveform captured before each latched frame
// - Low-power mode latches every second frame
module slcd_ctrl #(
    parameter bit WIDE_VARIANT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    input wire logic ext_clock_input_sel,
    input wire logic timer_osc_clk,
    input wire logic ext_clk_in,
    output logic frame_irq,
    output logic [3:0] com_drive_en,
    output logic [39:0] seg_drive_en,
    output logic lcd_grounded,
    output logic wave_low_power,
    output logic bias_half,
    output logic bias_static,
    output logic [2:0] frame_phase
);
    // ==================================================================
    // Register state
    logic display_drive_on; // Controller enable
    logic low_power_wave_sel; // Requested waveform
    logic frame_start_flag; // Sticky start-of-frame flag
    logic frame_irq_enable; // Start-of-frame interrupt enable
    logic blank_request; // Requested blanking
    logic async_clock_sel; // LCD clock source
    logic half_bias_sel; // Half bias request
    logic [1:0] duty_select; // Common multiplex
    logic [3:0] segment_pin_mask; // Segment pin count code
    logic [2:0] prescaler_tap; // Prescaler tap code
    logic [2:0] clock_divider_sel; // Divider minus one
    // Working copies taken at the frame latch, pair tracking and run state
    logic wave_cur; // Waveform in force
    logic blank_cur; // Blanking in force
    logic pair_second; // Next frame closes a low-power pair
    slcd_pkg::slcd_state_t state; // Running or idle

    // ==================================================================
    // Bus decode
    logic sel_a; // Control register A addressed
    logic sel_b; // Control register B addressed
    logic sel_f; // Frame rate register addressed
    logic hit; // Any register addressed
    logic acc_start; // First access cycle, answer is prepared
    logic wr_done; // Completing write edge
    logic wr_a; // Write to control A
    logic wr_b; // Write to control B
    logic wr_f; // Write to frame rate register
    logic [7:0] rd_a; // Read image of control A
    logic [7:0] rd_b; // Read image of control B
    logic [7:0] rd_f; // Read image of frame rate register
    logic [7:0] rd_mux; // Selected read image
    logic [3:0] pm_wr; // Mask value accepted on write

    assign sel_a = (paddr == slcd_pkg::ADDR_CTRL_A);
    assign sel_b = (paddr == slcd_pkg::ADDR_CTRL_B);
    assign sel_f = (paddr == slcd_pkg::ADDR_FRAME);
    assign hit = sel_a | sel_b | sel_f;
    assign acc_start = ce & psel & penable & ~pready;
    assign wr_done = ce & psel & penable & pready & pwrite & ~pslverr;
    assign wr_a = wr_done & sel_a;
    assign wr_b = wr_done & sel_b;
    assign wr_f = wr_done & sel_f;

    // Reserved bits are held at zero in every image
    assign rd_a = {display_drive_on, low_power_wave_sel, 1'b0,
                   frame_start_flag, frame_irq_enable, 2'b00,
                   blank_request};
    assign rd_b = {async_clock_sel, half_bias_sel, duty_select,
                   segment_pin_mask};
    assign rd_f = {1'b0, prescaler_tap, 1'b0, clock_divider_sel};
    assign rd_mux = sel_a ? rd_a : (sel_b ? rd_b : (sel_f ? rd_f : 8'h00));

    // Narrow variant keeps the top mask bit at zero
    assign pm_wr = WIDE_VARIANT ? pwdata[slcd_pkg::B_PM_LO +: 4] :
        {1'b0, pwdata[slcd_pkg::B_PM_LO +: 3]};

    // ==================================================================
    // Clock source and prescaler
    logic async_src; // Chosen asynchronous source
    logic async_rise; // Resynchronised edge of it
    logic lcd_tick; // One LCD clock period elapsed
    logic ps_tick; // Prescaled display clock tick
    logic run; // Controller running

    assign async_src = ext_clock_input_sel ? ext_clk_in : timer_osc_clk;
    assign lcd_tick = async_clock_sel ? async_rise : 1'b1;
    assign run = (state == slcd_pkg::SLCD_RUN);

    slcd_edge_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(async_src),
        .rise(async_rise)
    );

    slcd_clk_gen u_clk (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .run(run),
        .lcd_tick(lcd_tick),
        .prescaler_tap(prescaler_tap),
        .clock_divider_sel(clock_divider_sel),
        .prescaled_display_clock(ps_tick)
    );

    // ==================================================================
    // Frame timing
    logic [2:0] frame_last; // Last phase of a frame
    logic frame_tick; // Frame boundary
    logic latch_evt; // Working copies and flag updated
    logic flag_clr; // Flag clear request
    logic next_flag; // Next flag value

    // Frame length depends on duty
    function automatic logic [2:0] frame_len(input logic [1:0] d);
        frame_len = (d == slcd_pkg::DUTY_THIRD) ? slcd_pkg::FRAME_K_THIRD :
            slcd_pkg::FRAME_K_STD;
    endfunction

    assign frame_last = frame_len(duty_select);
    assign frame_tick = run & ps_tick & (frame_phase >= frame_last);
    assign latch_evt = frame_tick & (~wave_cur | pair_second);

    // Set wins over the clear in the same cycle
    assign flag_clr = irq_vector_ack |
        (wr_a & pwdata[slcd_pkg::A_FLAG]);
    assign next_flag = latch_evt | (frame_start_flag & ~flag_clr);

    // ==================================================================
    // Pin enables
    logic [3:0] com_mask; // Commons used by duty
    logic [39:0] seg_mask; // Segments used by port mask

    // Duty code to used commons
    function automatic logic [3:0] com_fn(input logic [1:0] d);
        com_fn = 4'hf >> (2'h3 - d);
    endfunction

    // Port mask code to driven segment pins
    function automatic logic [39:0] seg_fn(input logic [3:0] c);
        logic [5:0] n;
        n = slcd_pkg::SEG_C15;
        if (c < 4'h6)
            n = slcd_pkg::SEG_BASE + {1'b0, c, 1'b0};
        else if (c == 4'h6)
            n = slcd_pkg::SEG_C6;
        else if (c == 4'h7)
            n = slcd_pkg::SEG_C7;
        else if (c != 4'hf)
            n = slcd_pkg::SEG_BASE_HI + {1'b0, c - 4'h8, 1'b0};
        seg_fn = {slcd_pkg::SEG_N{1'b1}} >> (6'(slcd_pkg::SEG_N) - n);
    endfunction

    assign com_mask = com_fn(duty_select);
    assign seg_mask = seg_fn(segment_pin_mask);

    // ==================================================================
    // APB answer: one wait cycle, then pready for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            pready <= acc_start;
            if (acc_start) begin
                pslverr <= ~hit;
                prdata <= {24'h000000, rd_mux};
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Register writes from the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {display_drive_on, low_power_wave_sel} <= 2'b00;
            frame_irq_enable <= 1'b0;
            blank_request <= 1'b0;
            {async_clock_sel, half_bias_sel, duty_select,
             segment_pin_mask} <= slcd_pkg::REG_RESET;
            {prescaler_tap, clock_divider_sel} <= 6'h00;
        end else if (ce) begin
            if (wr_a) begin
                display_drive_on <= pwdata[slcd_pkg::A_EN];
                low_power_wave_sel <= pwdata[slcd_pkg::A_WAVE];
                frame_irq_enable <= pwdata[slcd_pkg::A_IE];
                blank_request <= pwdata[slcd_pkg::A_BLANK];
            end
            if (wr_b) begin
                async_clock_sel <= pwdata[slcd_pkg::B_CS];
                half_bias_sel <= pwdata[slcd_pkg::B_HALF];
                duty_select <= pwdata[slcd_pkg::B_DUTY_LO +: 2];
                segment_pin_mask <= pm_wr;
            end
            if (wr_f) begin
                prescaler_tap <= pwdata[slcd_pkg::F_PS_LO +: 3];
                clock_divider_sel <= pwdata[slcd_pkg::F_CD_LO +: 3];
            end
        end
    end

    // Run state: stops at once when enable clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= slcd_pkg::SLCD_IDLE;
        end else if (ce) begin
            case (state)
                slcd_pkg::SLCD_IDLE: begin
                    if (display_drive_on)
                        state <= slcd_pkg::SLCD_RUN;
                end
                slcd_pkg::SLCD_RUN: begin
                    if (!display_drive_on)
                        state <= slcd_pkg::SLCD_IDLE;
                end
                default: state <= slcd_pkg::SLCD_IDLE;
            endcase
        end
    end

    // Frame phase, pair tracking and working copies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_phase <= 3'h0;
            pair_second <= 1'b0;
            wave_cur <= 1'b0;
            blank_cur <= 1'b0;
            frame_start_flag <= 1'b0;
        end else if (ce) begin
            frame_start_flag <= next_flag;
            if (!run) begin
                frame_phase <= 3'h0;
                pair_second <= 1'b0;
            end else if (ps_tick) begin
                frame_phase <= frame_tick ? 3'h0 : frame_phase + 3'h1;
                if (frame_tick)
                    pair_second <= wave_cur & ~pair_second;
            end
            if (latch_evt) begin
                wave_cur <= low_power_wave_sel;
                blank_cur <= blank_request;
            end
        end
    end

    // Registered pin controls and interrupt request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_irq <= 1'b0;
            com_drive_en <= 4'h0;
            seg_drive_en <= '0;
            lcd_grounded <= 1'b0;
            wave_low_power <= 1'b0;
            bias_half <= 1'b0;
            bias_static <= 1'b0;
        end else if (ce) begin
            frame_irq <= frame_start_flag & frame_irq_enable &
                global_irq_enable;
            com_drive_en <= display_drive_on ? com_mask : 4'h0;
            seg_drive_en <= display_drive_on ? seg_mask : '0;
            lcd_grounded <= display_drive_on & blank_cur;
            wave_low_power <= wave_cur;
            bias_static <= (duty_select == slcd_pkg::DUTY_STATIC);
            bias_half <= half_bias_sel &
                (duty_select != slcd_pkg::DUTY_STATIC);
        end
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_off_pins;
        ce && !display_drive_on |=> com_drive_en == 4'h0 &&
            seg_drive_en == '0;
    endproperty
    a_off_pins: assert property (p_off_pins)
        else $error("pins still driven while disabled");

    property p_stop_now;
        ce && run && !display_drive_on |=> !run;
    endproperty
    a_stop_now: assert property (p_stop_now)
        else $error("controller did not stop at once");

    property p_wave_frame;
        ce && $changed(wave_cur) |-> $past(latch_evt);
    endproperty
    a_wave_frame: assert property (p_wave_frame)
        else $error("waveform changed off a frame boundary");

    property p_flag_set;
        ce && latch_evt |=> frame_start_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("frame flag not set at latch");

    sequence s_irq_cause;
        ce && frame_start_flag && frame_irq_enable && global_irq_enable;
    endsequence
    property p_irq;
        s_irq_cause ##1 ce |-> frame_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    property p_flag_clr;
        ce && irq_vector_ack && !latch_evt |=> !frame_start_flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("flag not cleared by vector");

    property p_flag_keep;
        ce && wr_a && !pwdata[slcd_pkg::A_FLAG] && !irq_vector_ack &&
            frame_start_flag |=> frame_start_flag;
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("writing zero cleared the flag");

    property p_lp_pair;
        latch_evt && wave_cur |=> !latch_evt [*8];
    endproperty
    a_lp_pair: assert property (p_lp_pair)
        else $error("low-power latch too soon");

    property p_rsvd;
        pready && sel_a |-> prdata[5] == 1'b0 && prdata[2:1] == 2'b00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits read nonzero");

    property p_blank;
        ce && display_drive_on && blank_cur |=> lcd_grounded;
    endproperty
    a_blank: assert property (p_blank)
        else $error("blanking did not ground pins");

    property p_static;
        ce && duty_select == slcd_pkg::DUTY_STATIC |=>
            bias_static && !bias_half && (!$past(display_drive_on) ||
            com_drive_en == 4'h1);
    endproperty
    a_static: assert property (p_static)
        else $error("static duty without static bias");
endmodule

/* sim/slcd_glass.sv */
// Passive segment glass model counting the terminals driven by the block
`timescale 1ns/1ps
module slcd_glass (
    input wire logic [3:0] com_drive_en,
    input wire logic [39:0] seg_drive_en,
    input wire logic lcd_grounded,
    output int com_count,
    output int seg_count
);
    // ============================================================
    // Terminals left to port function count as not driven
    assign com_count = $countones(com_drive_en);
    assign seg_count = $countones(seg_drive_en);
endmodule

/* sim/segment_lcd_control_tb_top.sv */
// Self-checking bench for the segment display control block
`timescale 1ns/1ps
module segment_lcd_control_tb_top;
    `define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
        err_total++; $display("unexpected %s exp %h got %h", nm, e, s); end end
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, gie = 0, ack = 0, frame_irq, grounded;
    logic wave, bias_half, bias_static;
    logic [3:0] com_en;
    logic [2:0] phase;
    logic [39:0] seg_en;
    int com_count, seg_count, err_total = 0, n_checks = 0, n, i, d, m;
    // Register rows: address, write value, expected read-back
    logic [27:0] rows [4] = '{{12'h394, 8'hff, 8'hff}, {12'h398, 8'hff,
        8'h77}, {12'h390, 8'h6f, 8'h49}, {12'h390, 8'h00, 8'h00}};
    // ============================================================
    // Clock and instances
    always #5 pclk = ~pclk;
    slcd_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_irq_enable(gie), .irq_vector_ack(ack),
        .ext_clock_input_sel(1'b0), .timer_osc_clk(1'b0),
        .ext_clk_in(1'b0), .frame_irq(frame_irq), .com_drive_en(com_en),
        .seg_drive_en(seg_en), .lcd_grounded(grounded),
        .wave_low_power(wave), .bias_half(bias_half),
        .bias_static(bias_static), .frame_phase(phase));
    slcd_glass glass (.com_drive_en(com_en), .seg_drive_en(seg_en),
        .lcd_grounded(grounded), .com_count(com_count),
        .seg_count(seg_count));
    // ============================================================
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] dat);
        int k;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a;
        pwdata <= {24'h0, dat};
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        // A transfer that never completes counts as a mismatch
        if (pready !== 1'b1) err_total++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Let register changes reach the pin outputs
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask
    // Closing task: counts and verdict
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #400000;
        err_total++;
        print_verdict();
    end
    // ============================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 3; i++) begin
            apb(0, 12'h390 + 12'(4 * i), 8'h00);
            `CHK("reset value", 32'h0, rd)
        end
        apb(0, 12'h39c, 8'h00);
        `CHK("unmapped error", 1'b1, err)
        $display("test reset done");
        foreach (rows[r]) begin
            apb(1, rows[r][27:16], rows[r][15:8]);
            apb(0, rows[r][27:16], 8'h00);
            `CHK("read back", {24'h0, rows[r][7:0]}, rd)
        end
        $display("test registers done");
        apb(1, 12'h398, 8'h00);
        apb(1, 12'h390, 8'h80);
        for (d = 0; d < 4; d++) for (m = 0; m < 16; m++) begin
            apb(1, 12'h394, {1'b0, m[0], d[1:0], m[3:0]});
            settle();
            `CHK("commons", d + 1, com_count)
            `CHK("static bias", d == 0, bias_static)
            if (d != 0) `CHK("half bias", m[0], bias_half)
            n = m < 6 ? 13 + 2 * m : m == 6 ? 24 : m == 7 ? 25 :
                m == 15 ? 40 : 27 + 2 * (m - 8);
            `CHK("segments", n, seg_count)
        end
        $display("test duty and mask done");
        gie <= 1;
        apb(1, 12'h390, 8'h88);
        for (n = 0; n < 300 && frame_irq !== 1'b1; n++) @(posedge pclk);
        `CHK("frame irq", 1'b1, frame_irq)
        apb(0, 12'h390, 8'h00);
        `CHK("flag set", 32'h98, rd)
        apb(1, 12'h390, 8'h88);
        apb(0, 12'h390, 8'h00);
        `CHK("write zero keeps", 32'h98, rd)
        apb(1, 12'h390, 8'h98);
        apb(0, 12'h390, 8'h00);
        `CHK("write one clears", 32'h88, rd)
        $display("test frame flag done");
        apb(1, 12'h390, 8'hc8);
        settle();
        `CHK("wave deferred", 1'b0, wave)
        for (n = 0; n < 300 && wave !== 1'b1; n++) @(posedge pclk);
        `CHK("wave applied", 1'b1, wave)
        for (n = 0; n < 600 && frame_irq !== 1'b1; n++) @(posedge pclk);
        ack <= 1;
        @(posedge pclk);
        ack <= 0;
        for (n = 0; n < 9 && frame_irq !== 1'b0; n++) @(posedge pclk);
        `CHK("vector clears", 1'b0, frame_irq)
        for (n = 0; n < 600 && frame_irq !== 1'b1; n++) @(posedge pclk);
        `CHK("every second frame", 1'b1, n > 200 && n < 600)
        $display("test low power done");
        apb(1, 12'h390, 8'h81);
        for (n = 0; n < 300 && grounded !== 1'b1; n++) @(posedge pclk);
        `CHK("blanked", 1'b1, grounded)
        apb(1, 12'h390, 8'h00);
        settle();
        `CHK("drive off", 4'h0, com_en)
        `CHK("port function", 40'h0, seg_en)
        `CHK("phase idle", 3'h0, phase)
        $display("test blank and disable done");
        print_verdict();
    end
endmodule
